// File: include/uart_rx_pkg.sv
/*
 * Constants and carrier types for the receive side of the queued serial unit.
 * Assumes one 100 MHz system clock and an asynchronous active-low reset.
 */
// Notes on behaviour
// - The line break flag sets when a framing-error character is followed by an all-zero framing-error character.
// - Line break, frame fault and parity fault flags are cleared by reset and held clear in standby.
// - Software may clear the line break flag by writing 0 only after it has read the flag as 1.
// - After a break is detected, the following all-zero characters are not moved into the receive queue.
// - Once the line returns to mark level 1, received characters go into the queue again.
// - The frame fault flag, bit 3, shows the framing error of the character now at the queue read port.
// - The frame fault flag drops by itself when the read character has no framing error.
// - In asynchronous mode the parity fault flag, bit 2, shows the parity error of the character at the read port.
// - The parity fault flag drops by itself when the read character has good parity.
// - A character completed while the queue holds 16 sets the overrun flag and is discarded.
// - A framing error does not stop the character from being stored.
// - A parity mismatch against the selected even or odd parity is flagged and the character still stored.
// - With modem control enabled, request-to-send is driven low while the queue can accept data.
// - Request-to-send goes high when the queue is full; the remote end must then hold off.
// - Transmit and receive queues are separate sixteen-entry buffers.
package uart_rx_pkg;

    localparam int QUEUE_DEPTH      = 16;
    localparam int DATA_WIDTH       = 8;
    localparam int OVERSAMPLE       = 16;
    localparam int FRAME_FAULT_BIT  = 3;
    localparam int PARITY_FAULT_BIT = 2;
    localparam int LINE_BREAK_BIT   = 4;
    localparam int OVERRUN_BIT      = 0;
    localparam int DIVISOR_WIDTH    = 8;
    localparam int PRESCALE_WIDTH   = 2;
    localparam logic [7:0] BREAK_DATA = 8'h00;

    typedef struct packed {
        logic                  parity_fault;
        logic                  frame_fault;
        logic [DATA_WIDTH-1:0] data;
    } rx_entry_type;

    typedef struct packed {
        logic                      parity_enable;
        logic                      parity_odd;
        logic [PRESCALE_WIDTH-1:0] prescale;
        logic [DIVISOR_WIDTH-1:0]  divisor;
    } serial_mode_setup_type;

endpackage

// File: core/rx_queue.sv
/*
 * Sixteen-entry first-in first-out store for received characters.
 * Assumes the writer never pushes while full and the reader never pops while empty.
 */
`timescale 1ns/100ps
module rx_queue #(
    parameter int DEPTH = 16,
    parameter int WIDTH = 10
) (
    input  wire logic             sys_clk,
    input  wire logic             rst_n,
    input  wire logic             flush,
    input  wire logic             push,
    input  wire logic [WIDTH-1:0] push_data,
    input  wire logic             pop,
    output logic      [WIDTH-1:0] head,
    output logic                  empty,
    output logic                  full
);
    localparam int AW = $clog2(DEPTH);

    initial begin
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin
            $error("rx_queue depth must be a power of two");
        end
    end

    logic [WIDTH-1:0] store [DEPTH];
    logic [AW:0]      wr_ptr;
    logic [AW:0]      rd_ptr;
    logic [AW:0]      next_wr_ptr;
    logic [AW:0]      next_rd_ptr;

    always_comb begin
        next_wr_ptr = wr_ptr;
        next_rd_ptr = rd_ptr;
        if (flush) begin
            next_wr_ptr = '0;
            next_rd_ptr = '0;
        end else begin
            if (push && !full) begin
                next_wr_ptr = wr_ptr + 1'b1;
            end
            if (pop && !empty) begin
                next_rd_ptr = rd_ptr + 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (push && !full && !flush) begin
            store[wr_ptr[AW-1:0]] <= push_data;
        end
    end

    assign head  = store[rd_ptr[AW-1:0]];
    assign empty = (wr_ptr == rd_ptr);
    assign full  = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);

endmodule // rx_queue

// File: core/uart_receive_error_flow.sv
/*
 * Receive side of the queued serial unit: bit-rate generator, oversampled
 * receiver, sixteen-entry receive queue, error flags and request-to-send.
 * Assumes rx_line and cts-free operation; all control bits arrive as plain
 * ports from logic on sys_clk, and rx_line comes from a pin.
 */
`timescale 1ns/100ps
module uart_receive_error_flow #(
    parameter int QUEUE_DEPTH = uart_rx_pkg::QUEUE_DEPTH
) (
    input  wire logic                              sys_clk,
    input  wire logic                              rst_n,
    input  wire logic                              rx_line,
    input  wire logic                              standby,
    input  wire logic                              rx_enable,
    input  wire logic                              modem_control,
    input  wire uart_rx_pkg::serial_mode_setup_type serial_mode_setup,
    input  wire logic                              rx_queue_read,
    input  wire logic                              line_break_flag_read,
    input  wire logic                              line_break_flag_write_zero,
    input  wire logic                              overrun_fault_flag_clear,
    output logic      [uart_rx_pkg::DATA_WIDTH-1:0] rx_queue_read_port,
    output logic                                   rx_data_ready,
    output logic                                   frame_fault_flag,
    output logic                                   parity_fault_flag,
    output logic                                   line_break_flag,
    output logic                                   overrun_fault_flag,
    output logic                                   rts_n
);
    localparam int DW = uart_rx_pkg::DATA_WIDTH;
    localparam int EW = DW + 2;

    initial begin
        if (QUEUE_DEPTH != uart_rx_pkg::QUEUE_DEPTH) begin
            $error("receive queue depth is fixed at sixteen");
        end
    end

    // ****************************************
    // Pin synchroniser
    // ****************************************
    logic rx_meta;
    logic rx_sync;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_meta <= 1'b1;
            rx_sync <= 1'b1;
        end else begin
            rx_meta <= rx_line;
            rx_sync <= rx_meta;
        end
    end

    // ****************************************
    // Bit-rate generator
    // ****************************************
    // Sample tick every (4^prescale)*(divisor+1) clocks, sixteen ticks per bit
    logic [7:0] pre_count;
    logic [7:0] next_pre_count;
    logic [7:0] div_count;
    logic [7:0] next_div_count;
    logic       tick;
    logic       next_tick;
    logic [7:0] pre_limit;

    always_comb begin
        case (serial_mode_setup.prescale)
            2'h0:    pre_limit = 8'h00;
            2'h1:    pre_limit = 8'h03;
            2'h2:    pre_limit = 8'h0F;
            default: pre_limit = 8'h3F;
        endcase
        next_pre_count = pre_count + 8'h01;
        next_div_count = div_count;
        next_tick      = 1'b0;
        if (pre_count >= pre_limit) begin
            next_pre_count = 8'h00;
            if (div_count >= serial_mode_setup.divisor) begin
                next_div_count = 8'h00;
                next_tick      = 1'b1;
            end else begin
                next_div_count = div_count + 8'h01;
            end
        end
        if (standby) begin
            next_pre_count = 8'h00;
            next_div_count = 8'h00;
            next_tick      = 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pre_count <= 8'h00;
            div_count <= 8'h00;
            tick      <= 1'b0;
        end else begin
            pre_count <= next_pre_count;
            div_count <= next_div_count;
            tick      <= next_tick;
        end
    end

    // ****************************************
    // Receiver
    // ****************************************
    typedef enum logic [2:0] {idle_type_s, start_s, data_s, parity_s, stop_s} rx_state_type;

    rx_state_type  state;
    rx_state_type  next_state;
    logic [3:0]    phase;
    logic [3:0]    next_phase;
    logic [2:0]    bit_index;
    logic [2:0]    next_bit_index;
    logic [DW-1:0] shift;
    logic [DW-1:0] next_shift;
    logic          parity_bad;
    logic          next_parity_bad;
    logic          done;
    logic          next_done;
    logic          done_frame_fault;
    logic          next_done_frame_fault;

    always_comb begin
        next_state            = state;
        next_phase            = phase;
        next_bit_index        = bit_index;
        next_shift            = shift;
        next_parity_bad       = parity_bad;
        next_done             = 1'b0;
        next_done_frame_fault = done_frame_fault;
        if (tick) begin
            next_phase = phase + 4'h1;
            case (state)
                idle_type_s: begin
                    next_phase = 4'h0;
                    if (!rx_sync && rx_enable) begin
                        next_state = start_s;
                    end
                end
                start_s: begin
                    if (phase == 4'h7) begin
                        next_phase = 4'h0;
                        next_state = rx_sync ? idle_type_s : data_s;
                        next_bit_index = 3'h0;
                    end
                end
                data_s: begin
                    if (phase == 4'hF) begin
                        next_shift = {rx_sync, shift[DW-1:1]};
                        next_bit_index = bit_index + 3'h1;
                        if (bit_index == 3'h7) begin
                            next_state = serial_mode_setup.parity_enable ? parity_s : stop_s;
                        end
                    end
                end
                parity_s: begin
                    if (phase == 4'hF) begin
                        next_parity_bad = (^shift ^ rx_sync) != serial_mode_setup.parity_odd;
                        next_state = stop_s;
                    end
                end
                default: begin
                    if (phase == 4'hF) begin
                        next_done_frame_fault = !rx_sync;
                        next_done = 1'b1;
                        next_state = idle_type_s;
                    end
                end
            endcase
        end
        if (state == idle_type_s && tick && !serial_mode_setup.parity_enable) begin
            next_parity_bad = 1'b0;
        end
        if (standby) begin
            next_state = idle_type_s;
            next_phase = 4'h0;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state            <= idle_type_s;
            phase            <= 4'h0;
            bit_index        <= 3'h0;
            shift            <= '0;
            parity_bad       <= 1'b0;
            done             <= 1'b0;
            done_frame_fault <= 1'b0;
        end else begin
            state            <= next_state;
            phase            <= next_phase;
            bit_index        <= next_bit_index;
            shift            <= next_shift;
            parity_bad       <= next_parity_bad;
            done             <= next_done;
            done_frame_fault <= next_done_frame_fault;
        end
    end

    // ****************************************
    // Receive queue, break and overrun
    // ****************************************
    uart_rx_pkg::rx_entry_type entry_in;
    uart_rx_pkg::rx_entry_type entry_head;
    logic q_empty;
    logic q_full;
    logic q_push;
    logic q_pop;
    logic prev_fault;
    logic next_prev_fault;
    logic break_hold;
    logic next_break_hold;
    logic break_flag;
    logic next_break_flag;
    logic break_seen_one;
    logic next_break_seen_one;
    logic overrun;
    logic next_overrun;
    logic is_break_char;

    assign entry_in      = '{parity_fault: parity_bad, frame_fault: done_frame_fault, data: shift};
    assign is_break_char = done && done_frame_fault && (shift == uart_rx_pkg::BREAK_DATA);
    assign q_pop         = rx_queue_read && !q_empty;

    always_comb begin
        next_prev_fault     = prev_fault;
        next_break_hold     = break_hold;
        next_break_flag     = break_flag;
        next_break_seen_one = break_seen_one;
        next_overrun        = overrun;
        q_push              = 1'b0;
        if (break_hold && rx_sync) begin
            next_break_hold = 1'b0;
        end
        if (line_break_flag_read && break_flag) begin
            next_break_seen_one = 1'b1;
        end
        if (line_break_flag_write_zero && break_seen_one) begin
            next_break_flag     = 1'b0;
            next_break_seen_one = 1'b0;
        end
        if (overrun_fault_flag_clear) begin
            next_overrun = 1'b0;
        end
        if (done) begin
            next_prev_fault = done_frame_fault;
            if (is_break_char && (prev_fault || break_hold)) begin
                next_break_flag = 1'b1;
                next_break_hold = 1'b1;
            end
            if (break_hold && is_break_char) begin
                q_push = 1'b0;
            end else if (q_full) begin
                next_overrun = 1'b1;
            end else begin
                q_push = 1'b1;
            end
        end
        if (standby) begin
            next_break_flag     = 1'b0;
            next_break_seen_one = 1'b0;
            next_break_hold     = 1'b0;
            next_prev_fault     = 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            prev_fault     <= 1'b0;
            break_hold     <= 1'b0;
            break_flag     <= 1'b0;
            break_seen_one <= 1'b0;
            overrun        <= 1'b0;
        end else begin
            prev_fault     <= next_prev_fault;
            break_hold     <= next_break_hold;
            break_flag     <= next_break_flag;
            break_seen_one <= next_break_seen_one;
            overrun        <= next_overrun;
        end
    end

    // Separate receive store; the transmit store lives with the transmitter
    rx_queue #(
        .DEPTH (QUEUE_DEPTH),
        .WIDTH (EW)
    ) u_rx_queue (
        .sys_clk   (sys_clk),
        .rst_n     (rst_n),
        .flush     (standby),
        .push      (q_push),
        .push_data (entry_in),
        .pop       (q_pop),
        .head      (entry_head),
        .empty     (q_empty),
        .full      (q_full)
    );

    // ****************************************
    // Registered outputs
    // ****************************************
    // Frame and parity fault flags mirror the entry now at the read port, so they follow each pop
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_queue_read_port <= '0;
            rx_data_ready      <= 1'b0;
            frame_fault_flag   <= 1'b0;
            parity_fault_flag  <= 1'b0;
            line_break_flag    <= 1'b0;
            overrun_fault_flag <= 1'b0;
            rts_n              <= 1'b1;
        end else begin
            // Standby drops ready at once, so the port must read zero with it
            rx_queue_read_port <= (q_empty || standby) ? '0 : entry_head.data;
            rx_data_ready      <= !q_empty && !standby;
            frame_fault_flag   <= !q_empty && !standby && entry_head.frame_fault;
            parity_fault_flag  <= !q_empty && !standby && entry_head.parity_fault;
            line_break_flag    <= next_break_flag;
            overrun_fault_flag <= next_overrun;
            // Full raises the request line one clock after the last push
            rts_n <= modem_control ? q_full : 1'b0;
        end
    end

endmodule // uart_receive_error_flow

// File: test/uart_receive_error_flow_assertions.sv
/*
 * Checker for the receive error flow: port relations over time.
 * Assumes it is bound to every instance of uart_receive_error_flow.
 */
`timescale 1ns/100ps
module uart_receive_error_flow_checker #(
    parameter int QUEUE_DEPTH = uart_rx_pkg::QUEUE_DEPTH
) (
    input wire logic                              sys_clk,
    input wire logic                              rst_n,
    input wire logic                              standby,
    input wire logic                              modem_control,
    input wire logic                              rx_queue_read,
    input wire logic                              line_break_flag_write_zero,
    input wire logic                              overrun_fault_flag_clear,
    input wire logic [uart_rx_pkg::DATA_WIDTH-1:0] rx_queue_read_port,
    input wire logic                              rx_data_ready,
    input wire logic                              frame_fault_flag,
    input wire logic                              parity_fault_flag,
    input wire logic                              line_break_flag,
    input wire logic                              overrun_fault_flag,
    input wire logic                              rts_n
);
    logic take_out;

    assign take_out = rx_queue_read | standby;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    a_rts_off_low: assert property (!modem_control |=> !rts_n)
        else $error("rts_n high with flow control off");
    a_standby_clears_flags: assert property (
        standby |=> !line_break_flag && !frame_fault_flag && !parity_fault_flag)
        else $error("flags not cleared by standby");
    a_break_clear_cause: assert property (
        $fell(line_break_flag) |-> $past(line_break_flag_write_zero) || $past(standby))
        else $error("line break flag dropped without clear");
    a_break_stays_set: assert property (
        line_break_flag && !line_break_flag_write_zero && !standby |=> line_break_flag)
        else $error("line break flag lost");
    a_overrun_stays_set: assert property (
        overrun_fault_flag && !overrun_fault_flag_clear |=> overrun_fault_flag)
        else $error("overrun flag lost");
    a_empty_port_zero: assert property (!rx_data_ready |-> rx_queue_read_port == '0)
        else $error("read port not zero while empty");
    a_head_holds_status: assert property (
        (!rx_queue_read && !standby)[*3] ##0 rx_data_ready |=> $stable(rx_queue_read_port)
        && $stable(frame_fault_flag) && $stable(parity_fault_flag))
        else $error("head or its status changed without a read");
    a_ready_fall_cause: assert property (
        $fell(rx_data_ready) |-> $past(take_out) || $past(take_out, 2) || $past(take_out, 3))
        else $error("queue emptied without read or standby");

    c_break_seen: cover property ($rose(line_break_flag));
    c_overrun_seen: cover property ($rose(overrun_fault_flag));
    c_queue_full: cover property ($rose(rts_n));
    c_frame_drop: cover property ($fell(frame_fault_flag));
endmodule // uart_receive_error_flow_checker

bind uart_receive_error_flow uart_receive_error_flow_checker #(.QUEUE_DEPTH(QUEUE_DEPTH)) checker_inst (
    .sys_clk(sys_clk), .rst_n(rst_n), .standby(standby), .modem_control(modem_control),
    .rx_queue_read(rx_queue_read), .line_break_flag_write_zero(line_break_flag_write_zero),
    .overrun_fault_flag_clear(overrun_fault_flag_clear), .rx_queue_read_port(rx_queue_read_port),
    .rx_data_ready(rx_data_ready), .frame_fault_flag(frame_fault_flag),
    .parity_fault_flag(parity_fault_flag), .line_break_flag(line_break_flag),
    .overrun_fault_flag(overrun_fault_flag), .rts_n(rts_n));

// File: test/remote_tx_model.sv
/*
 * Remote serial transmitter on the far side of the receive pin.
 * Assumes its tasks are called one at a time, at a falling clock edge.
 */
`timescale 1ns/100ps
module remote_tx_model #(
    parameter int BIT = 80
) (
    input  wire logic sys_clk,
    input  wire logic rts_n,
    output logic      rx_line
);
    initial rx_line = 1'b1;

    task automatic rest(input logic lvl, input int clocks);
        rx_line = lvl;
        repeat (clocks) @(negedge sys_clk);
    endtask

    task automatic send(input logic [7:0] d, input logic par_en, input logic odd, input logic bad_par,
                        input logic stop, input logic force_tx);
        // Hold off while the far queue is full, unless an overrun is wanted
        while (rts_n !== 1'b0 && !force_tx) @(negedge sys_clk);
        rest(1'b0, BIT);
        for (int i = 0; i < 8; i++) rest(d[i], BIT);
        if (par_en) rest(^d ^ odd ^ bad_par, BIT);
        // Low stop cut short, else the receiver may take it for a start
        rest(stop, stop ? BIT : 3 * BIT / 4);
    endtask
endmodule // remote_tx_model

// File: test/testbench.sv
/*
 * Self-checking bench: reset values, parity and framing status, break,
 * overrun with flow control, standby.
 * Assumes remote_tx_model on the pin and the bound checker.
 */
`timescale 1ns/100ps
module testbench;
    // Prescale 0, divisor 4: tick of 5 clocks, 16 ticks a bit
    localparam int BIT = 80;

    logic                               sys_clk, rst_n, rx_line, standby, modem_control;
    uart_rx_pkg::serial_mode_setup_type mode;
    logic                               rx_queue_read, line_break_flag_read;
    logic                               line_break_flag_write_zero, overrun_fault_flag_clear;
    logic [7:0]                         rx_queue_read_port;
    logic                               rx_data_ready, frame_fault_flag, parity_fault_flag;
    logic                               line_break_flag, overrun_fault_flag, rts_n;
    int                                 error_cnt = 0;
    int                                 checks_done = 0;

    uart_receive_error_flow dut (
        .sys_clk(sys_clk), .rst_n(rst_n), .rx_line(rx_line), .standby(standby), .rx_enable(1'b1),
        .modem_control(modem_control), .serial_mode_setup(mode), .rx_queue_read(rx_queue_read),
        .line_break_flag_read(line_break_flag_read), .line_break_flag_write_zero(line_break_flag_write_zero),
        .overrun_fault_flag_clear(overrun_fault_flag_clear), .rx_queue_read_port(rx_queue_read_port),
        .rx_data_ready(rx_data_ready), .frame_fault_flag(frame_fault_flag),
        .parity_fault_flag(parity_fault_flag), .line_break_flag(line_break_flag),
        .overrun_fault_flag(overrun_fault_flag), .rts_n(rts_n));

    remote_tx_model #(.BIT(BIT)) remote (.sys_clk(sys_clk), .rts_n(rts_n), .rx_line(rx_line));

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    task automatic check(input string w, input logic [7:0] e, input logic [7:0] g);
        checks_done++;
        if (g !== e) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", w, e, g);
        end
    endtask

    task automatic flag(input string w, input logic e, input logic g);
        check(w, {7'h00, e}, {7'h00, g});
    endtask

    task automatic head(input logic [7:0] d, input logic fe, input logic pe);
        flag("ready", 1'b1, rx_data_ready);
        check("data", d, rx_queue_read_port);
        flag("frame fault", fe, frame_fault_flag);
        flag("parity fault", pe, parity_fault_flag);
    endtask

    task automatic pulse(ref logic s);
        @(negedge sys_clk) s = 1'b1;
        @(negedge sys_clk) s = 1'b0;
        repeat (2) @(negedge sys_clk);
    endtask

    task automatic settle();
        repeat (8) @(negedge sys_clk);
    endtask

    task automatic t_reset();
        flag("ready", 1'b0, rx_data_ready);
        flag("frame fault", 1'b0, frame_fault_flag);
        flag("parity fault", 1'b0, parity_fault_flag);
        flag("line break", 1'b0, line_break_flag);
        flag("rts_n", 1'b0, rts_n);
    endtask

    task automatic t_parity();
        for (int k = 0; k < 2; k++) begin
            mode.parity_enable = 1'b1;
            mode.parity_odd    = k[0];
            remote.send(8'h3C, 1'b1, k[0], 1'b1, 1'b1, 1'b0);
            remote.send(8'hA5, 1'b1, k[0], 1'b0, 1'b1, 1'b0);
            settle();
            head(8'h3C, 1'b0, 1'b1);
            pulse(rx_queue_read);
            head(8'hA5, 1'b0, 1'b0);
            pulse(rx_queue_read);
        end
        mode.parity_enable = 1'b0;
    endtask

    task automatic t_frame();
        remote.send(8'h81, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
        remote.rest(1'b1, 2 * BIT);
        remote.send(8'h42, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
        settle();
        head(8'h81, 1'b1, 1'b0);
        pulse(rx_queue_read);
        head(8'h42, 1'b0, 1'b0);
        pulse(rx_queue_read);
    endtask

    task automatic t_break();
        remote.send(8'h55, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
        // Ends between a stop sample and the next start check
        remote.rest(1'b0, 19 * BIT);
        remote.rest(1'b1, 2 * BIT);
        remote.send(8'h3C, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
        settle();
        flag("line break", 1'b1, line_break_flag);
        head(8'h55, 1'b1, 1'b0);
        pulse(rx_queue_read);
        head(8'h00, 1'b1, 1'b0);
        pulse(rx_queue_read);
        head(8'h3C, 1'b0, 1'b0);
        pulse(rx_queue_read);
        pulse(line_break_flag_write_zero);
        flag("line break", 1'b1, line_break_flag);
        pulse(line_break_flag_read);
        pulse(line_break_flag_write_zero);
        flag("line break", 1'b0, line_break_flag);
    endtask

    task automatic t_overrun();
        modem_control = 1'b1;
        settle();
        flag("rts_n", 1'b0, rts_n);
        for (int i = 0; i < 16; i++) remote.send(8'h10 + 8'(i), 1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
        settle();
        flag("rts_n", 1'b1, rts_n);
        flag("overrun", 1'b0, overrun_fault_flag);
        remote.send(8'hEE, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1);
        settle();
        flag("overrun", 1'b1, overrun_fault_flag);
        for (int i = 0; i < 16; i++) begin
            head(8'h10 + 8'(i), 1'b0, 1'b0);
            pulse(rx_queue_read);
        end
        flag("ready", 1'b0, rx_data_ready);
        flag("rts_n", 1'b0, rts_n);
        pulse(overrun_fault_flag_clear);
        flag("overrun", 1'b0, overrun_fault_flag);
        modem_control = 1'b0;
    endtask

    task automatic t_standby();
        remote.send(8'h81, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
        remote.rest(1'b1, 2 * BIT);
        head(8'h81, 1'b1, 1'b0);
        pulse(standby);
        flag("frame fault", 1'b0, frame_fault_flag);
        flag("ready", 1'b0, rx_data_ready);
    endtask

    task automatic results();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        rst_n                      = 1'b0;
        standby                    = 1'b0;
        modem_control              = 1'b0;
        mode                       = '{1'b0, 1'b0, 2'h0, 8'h04};
        rx_queue_read              = 1'b0;
        line_break_flag_read       = 1'b0;
        line_break_flag_write_zero = 1'b0;
        overrun_fault_flag_clear   = 1'b0;
        repeat (5) @(negedge sys_clk);
        rst_n = 1'b1;
        settle();
        t_reset();
        t_parity();
        t_frame();
        t_break();
        t_overrun();
        t_standby();
        results();
    end

    // Full run needs about 25000 cycles; this leaves ample room
    initial begin
        repeat (60000) @(posedge sys_clk);
        error_cnt++;
        results();
    end
endmodule // testbench
